//--- src/tmr_ch3_consts.vh
// constants for the channel 3 register b/d i/o select decoder
`ifndef TMR_CH3_CONSTS_VH
`define TMR_CH3_CONSTS_VH
// axi4-lite byte addresses
`define ADDR_IO_CTRL_HIGH 4'h0
`define ADDR_IO_CTRL_LOW  4'h4
`define ADDR_MODE         4'h8
`define ADDR_CH4_CTRL     4'hC
`define ADDR_STATUS       5'h10
// field positions
`define FLD_HI            7
`define FLD_LO            4
`define MODE_BUF_BIT      5
`define CH4_PSC_HI        2
// reset values and the undivided prescaler code
`define IO_CTRL_RESET     8'h00
`define MODE_RESET        8'h00
`define CH4_CTRL_RESET    8'h00
`define PSC_UNDIVIDED     3'h0
// axi responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

//--- src/tmr_ch3_io_select.v
// channel 3 register b/d i/o select decoder with axi4-lite registers
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "tmr_ch3_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// one pin channel: compare output and capture decode for a 4-bit field
module io_sel_unit
(
    input  wire        clk,
    input  wire        rstn,
    input  wire [3:0]  mode,
    input  wire        disable_all,
    input  wire        psc_undiv,
    input  wire        cmp_match,
    input  wire        ch4_count,
    input  wire        pin_in,
    output reg         pin_out,
    output wire        pin_oe,
    output wire        capture,
    output wire        is_capture
);
    // pin, field and output-mode history
    reg        pin_prev;
    reg  [3:0] mode_prev;
    reg        out_prev;
    wire       out_mode;
    wire       rise;
    wire       fall;
    wire       mode_new;

    // top bit picks compare or capture; disable_all (buffer mode, on the d unit only) silences both
    assign out_mode   = ~mode[3] & ~disable_all;
    assign is_capture = mode[3] & ~disable_all;

    // pin edges against the previous sample
    assign rise       = pin_in & ~pin_prev;
    assign fall       = ~pin_in & pin_prev;

    // field value changed, or compare mode just re-entered after buffer mode
    assign mode_new   = (mode != mode_prev) | (out_mode & ~out_prev);

    // output enabled only for codes with nonzero action bits
    assign pin_oe = out_mode & (mode[1:0] != 2'h0); // [R1] [R12]

    // capture strobe selection
    assign capture = is_capture & (
        (mode[2] & ch4_count & ~psc_undiv) |                // [R9] [R10] [R11]
        (~mode[2] & ~mode[1] & ~mode[0] & rise) |           // [R4] [R5] [R6]
        (~mode[2] & ~mode[1] & mode[0] & fall) |            // [R7]
        (~mode[2] & mode[1] & (rise | fall)));              // [R8]

    // pin history and initial level / compare actions
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_prev  <= 1'b0;
            mode_prev <= 4'h0;
            out_prev  <= 1'b0;
            pin_out   <= 1'b0;
        end
        else
        begin
            pin_prev  <= pin_in;
            mode_prev <= mode;
            out_prev  <= out_mode;
            // a match in the cycle of a field change loses to the initial level
            if (!out_mode)
                pin_out <= 1'b0;
            else if (mode_new)
                pin_out <= mode[2];                          // [R13]
            else if (cmp_match)
            begin
                case (mode[1:0])
                    2'h1:    pin_out <= 1'b0;                // [R1]
                    2'h2:    pin_out <= 1'b1;                // [R2]
                    2'h3:    pin_out <= ~pin_out;            // [R3]
                    default: pin_out <= pin_out;
                endcase
            end
        end
    end
endmodule // io_sel_unit

////////////////////////////////////////////////////////////////////////////////
// Function
// [R1] 0000/0100 off; 0001/0101 drive low on match
// [R2] 0010/0110 init level, drive high on match
// [R3] 0011/0111 init level, toggle on match
// [R4] top bit set: reg b captures b pin
// [R5] top bit set: reg d captures d pin
// [R6] 1000 captures on rising edge
// [R7] 1001 captures on falling edge
// [R8] 101x captures on both edges
// [R9] 11xx captures on channel 4 count
// [R10] every channel 4 up/down count captures; code captures a count only when the channel 4 prescaler is not undivided
// [R11] undivided channel 4 clock: no capture
// [R12] buffer mode disables register d function
// [R13] initial level driven when field written; code drives it only on a field value change or when d leaves buffer mode
module tmr_ch3_io_select
(
    input  wire        clk,
    input  wire        rstn,
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        cmp_match_b,
    input  wire        cmp_match_d,
    input  wire        ch4_count,
    input  wire        ch3_pin_b_in,
    output wire        ch3_pin_b_out,
    output wire        ch3_pin_b_oe,
    input  wire        ch3_pin_d_in,
    output wire        ch3_pin_d_out,
    output wire        ch3_pin_d_oe,
    output wire        capture_b,
    output wire        capture_d
);
    // register file and write-channel holding state
    reg  [7:0]  ch3_io_ctrl_high;
    reg  [7:0]  ch3_io_ctrl_low;
    reg  [7:0]  ch3_mode_reg;
    reg  [7:0]  ch4_control;
    reg         aw_held;
    reg  [4:0]  aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg  [31:0] next_rdata;
    reg         next_rok;
    reg         wr_ok;
    wire        wr_fire;
    wire        buffer_mode_reg_b_d;
    wire        psc_undiv;
    wire        b_is_cap;
    wire        d_is_cap;

    // buffer mode bit and undivided channel 4 clock detect
    assign buffer_mode_reg_b_d = ch3_mode_reg[`MODE_BUF_BIT];
    assign psc_undiv = ch4_control[`CH4_PSC_HI:0] == `PSC_UNDIVIDED;

    ////////////////////////////////////////////////////////////////////////////
    // register b pin unit
    io_sel_unit u_b
    (
        .clk         (clk),
        .rstn        (rstn),
        .mode        (ch3_io_ctrl_high[`FLD_HI:`FLD_LO]),
        .disable_all (1'b0),
        .psc_undiv   (psc_undiv),
        .cmp_match   (cmp_match_b),
        .ch4_count   (ch4_count),
        .pin_in      (ch3_pin_b_in),
        .pin_out     (ch3_pin_b_out),
        .pin_oe      (ch3_pin_b_oe),
        .capture     (capture_b),
        .is_capture  (b_is_cap)
    );

    // register d pin unit, silenced in buffer mode
    io_sel_unit u_d
    (
        .clk         (clk),
        .rstn        (rstn),
        .mode        (ch3_io_ctrl_low[`FLD_HI:`FLD_LO]),
        .disable_all (buffer_mode_reg_b_d),                  // [R12]
        .psc_undiv   (psc_undiv),
        .cmp_match   (cmp_match_d),
        .ch4_count   (ch4_count),
        .pin_in      (ch3_pin_d_in),
        .pin_out     (ch3_pin_d_out),
        .pin_oe      (ch3_pin_d_oe),
        .capture     (capture_d),
        .is_capture  (d_is_cap)
    );

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel handshakes
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;

    // read address accepted whenever no read data is waiting
    assign s_axi_arready = ~s_axi_rvalid;

    // address decode for writes
    always @*
    begin
        case (aw_addr)
            {1'b0, `ADDR_IO_CTRL_HIGH}: wr_ok = 1'b1;
            {1'b0, `ADDR_IO_CTRL_LOW}:  wr_ok = 1'b1;
            {1'b0, `ADDR_MODE}:         wr_ok = 1'b1;
            {1'b0, `ADDR_CH4_CTRL}:     wr_ok = 1'b1;
            default:                    wr_ok = 1'b0;
        endcase
    end

    // write path and register storage
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_held          <= 1'b0;
            aw_addr          <= 5'h00;
            w_held           <= 1'b0;
            w_data           <= 32'h00000000;
            w_strb           <= 4'h0;
            s_axi_bvalid     <= 1'b0;
            s_axi_bresp      <= `RESP_OKAY;
            ch3_io_ctrl_high <= `IO_CTRL_RESET;
            ch3_io_ctrl_low  <= `IO_CTRL_RESET;
            ch3_mode_reg     <= `MODE_RESET;
            ch4_control      <= `CH4_CTRL_RESET;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            // both halves held: commit the write and raise the response
            if (wr_fire)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                // only byte lane 0 carries register data
                if (w_strb[0])
                begin
                    case (aw_addr)
                        {1'b0, `ADDR_IO_CTRL_HIGH}: ch3_io_ctrl_high <= w_data[7:0];
                        {1'b0, `ADDR_IO_CTRL_LOW}:  ch3_io_ctrl_low  <= w_data[7:0];
                        {1'b0, `ADDR_MODE}:         ch3_mode_reg     <= w_data[7:0];
                        {1'b0, `ADDR_CH4_CTRL}:     ch4_control      <= w_data[7:0];
                        default:                    ch4_control      <= ch4_control;
                    endcase
                end
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read decode, status shows live pin and capture state
    always @*
    begin
        next_rdata = 32'h00000000;
        next_rok   = 1'b1;
        case (s_axi_araddr)
            {1'b0, `ADDR_IO_CTRL_HIGH}: next_rdata[7:0] = ch3_io_ctrl_high;
            {1'b0, `ADDR_IO_CTRL_LOW}:  next_rdata[7:0] = ch3_io_ctrl_low;
            {1'b0, `ADDR_MODE}:         next_rdata[7:0] = ch3_mode_reg;
            {1'b0, `ADDR_CH4_CTRL}:     next_rdata[7:0] = ch4_control;
            `ADDR_STATUS:               next_rdata[5:0] = {d_is_cap, b_is_cap,
                                            ch3_pin_d_oe, ch3_pin_d_out,
                                            ch3_pin_b_oe, ch3_pin_b_out};
            // unmapped read answers with an error response
            default:                    next_rok = 1'b0;
        endcase
    end

    // read response register
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // tmr_ch3_io_select

//--- testbench/io_select_chk_assertions.sv
// checker for the channel 3 b/d i/o select decoder
`timescale 1ns/10ps
////////////////////////////////////////
module io_select_chk
(
    input wire clk,
    input wire rstn,
    input wire cmp_match_b,
    input wire cmp_match_d,
    input wire ch4_count,
    input wire ch3_pin_b_in,
    input wire ch3_pin_d_in,
    input wire ch3_pin_b_out,
    input wire ch3_pin_b_oe,
    input wire ch3_pin_d_out,
    input wire ch3_pin_d_oe,
    input wire capture_b,
    input wire capture_d,
    input wire s_axi_bvalid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // a capture needs a pin change or a channel 4 count, and never in output mode
    cap_b_cause_a: assert property (capture_b |-> ch4_count || $changed(ch3_pin_b_in))
        else $error("capture b without cause");
    cap_d_cause_a: assert property (capture_d |-> ch4_count || $changed(ch3_pin_d_in))
        else $error("capture d without cause");
    cap_b_mode_a: assert property (capture_b |-> !ch3_pin_b_oe)
        else $error("capture b while b drives");
    cap_d_mode_a: assert property (capture_d |-> !ch3_pin_d_oe)
        else $error("capture d while d drives");
    // pin levels move only after a match or a register write
    pin_b_cause_a: assert property ($changed(ch3_pin_b_out) |->
        $past(cmp_match_b) || $past(s_axi_bvalid))
        else $error("pin b moved without cause");
    pin_d_cause_a: assert property ($changed(ch3_pin_d_out) |->
        $past(cmp_match_d) || $past(s_axi_bvalid))
        else $error("pin d moved without cause");
    oe_b_write_a: assert property ($changed(ch3_pin_b_oe) |-> s_axi_bvalid)
        else $error("b enable moved without write");
    oe_d_write_a: assert property ($changed(ch3_pin_d_oe) |-> s_axi_bvalid)
        else $error("d enable moved without write");
    // main scenarios
    cover property (capture_b && ch4_count);
    cover property (capture_d && !ch4_count);
    cover property ($rose(ch3_pin_d_out));
endmodule // io_select_chk
bind tmr_ch3_io_select io_select_chk chk (.clk, .rstn, .cmp_match_b, .cmp_match_d, .ch4_count,
    .ch3_pin_b_in, .ch3_pin_d_in, .ch3_pin_b_out, .ch3_pin_b_oe, .ch3_pin_d_out,
    .ch3_pin_d_oe, .capture_b, .capture_d, .s_axi_bvalid);

//--- testbench/pin_ext.sv
// far-side pin model: external drivers on the b and d pins
`timescale 1ns/10ps
////////////////////////////////////////
module pin_ext
(
    input  wire ext_b,
    input  wire ext_d,
    input  wire clk,
    input  wire out_b,
    input  wire oe_b,
    input  wire out_d,
    input  wire oe_d,
    output wire pin_b,
    output wire pin_d
);
    reg drv_b = 1'h0;
    reg drv_d = 1'h0;
    // external level follows the request one edge later
    always @(posedge clk)
    begin
        drv_b <= ext_b;
        drv_d <= ext_d;
    end
    // the wire carries the device level while the device drives it
    assign pin_b = oe_b ? out_b : drv_b;
    assign pin_d = oe_d ? out_d : drv_d;
endmodule // pin_ext

//--- testbench/tb.sv
// self-checking bench for the channel 3 b/d i/o select decoder
`timescale 1ns/10ps
`include "tmr_ch3_consts.vh"
////////////////////////////////////////
module tb;
    reg         clk = 1'h0;
    reg         rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg         ext_b, ext_d, cmp_match_b, cmp_match_d, ch4_count;
    reg  [4:0]  s_axi_awaddr, s_axi_araddr, fa;
    reg  [31:0] s_axi_wdata, rv;
    reg  [3:0]  s_axi_wstrb;
    reg  [5:0]  m;
    reg  [1:0]  rr;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire        ch3_pin_b_in, ch3_pin_b_out, ch3_pin_b_oe, capture_b;
    wire        ch3_pin_d_in, ch3_pin_d_out, ch3_pin_d_oe, capture_d;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     bad_count = 0, total_checks = 0, cyc = 0, nc = 0, e, j, k;
    tmr_ch3_io_select dut (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_match_b,
        .cmp_match_d, .ch4_count, .ch3_pin_b_in, .ch3_pin_b_out, .ch3_pin_b_oe,
        .ch3_pin_d_in, .ch3_pin_d_out, .ch3_pin_d_oe, .capture_b, .capture_d);
    pin_ext far (.clk, .ext_b, .ext_d, .out_b(ch3_pin_b_out), .oe_b(ch3_pin_b_oe),
        .out_d(ch3_pin_d_out), .oe_d(ch3_pin_d_oe), .pin_b(ch3_pin_b_in), .pin_d(ch3_pin_d_in));
    // clock, capture counter and watchdog
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        nc <= nc + capture_b + capture_d;
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count = bad_count + 1;
            conclude;
        end
    end
    task conclude;
    begin
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("MISMATCH %0t value got %h exp %h", $time, got, exp);
        end
    end
    endtask
    // bus tasks: each valid held to the edge that takes it, answers taken where seen
    task wr(input [4:0] a, input [7:0] d);
        reg ta, tw, b;
    begin
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        {ta, tw, b} = 3'h0;
        while (!(ta && tw))
        begin
            @(posedge clk);
            if (!ta && s_axi_awready)
            begin
                ta = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!tw && s_axi_wready)
            begin
                tw = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        s_axi_bready <= 1'h1;
        while (!b)
        begin
            @(posedge clk);
            b = s_axi_bvalid;
        end
        rr = s_axi_bresp;
        s_axi_bready <= 1'h0;
    end
    endtask
    task rd(input [4:0] a);
        reg v;
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        v = 1'h0;
        while (!v)
        begin
            @(posedge clk);
            v = s_axi_arready;
        end
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        v = 1'h0;
        while (!v)
        begin
            @(posedge clk);
            v = s_axi_rvalid;
        end
        {rv, rr} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
    end
    endtask
    // status word over the bus and the pin ports themselves
    task sts(input [5:0] msk, input [5:0] x);
    begin
        rd(`ADDR_STATUS);
        chk(rv[5:0] & msk, x & msk);
        chk({ch3_pin_d_oe, ch3_pin_d_out, ch3_pin_b_oe, ch3_pin_b_out} & msk[3:0],
            x[3:0] & msk[3:0]);
    end
    endtask
    // s = {ext_b, ext_d, ch4 count, match b, match d}; x = captures expected
    task stim(input [4:0] s, input [31:0] x);
        integer base;
    begin
        base = nc;
        {ext_b, ext_d, ch4_count, cmp_match_b, cmp_match_d} <= s;
        @(posedge clk);
        {ch4_count, cmp_match_b, cmp_match_d} <= 3'h0;
        repeat (3) @(posedge clk);
        chk(nc - base, x);
    end
    endtask
    // main sequence
    initial
    begin
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {ext_b, ext_d, cmp_match_b, cmp_match_d, ch4_count, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        for (k = 0; k < 5; k = k + 1)
        begin
            rd({k[2:0], 2'h0});
            chk(rv, 32'h0);
        end
        rd(5'h14);
        chk(rr, `RESP_SLVERR);
        wr(`ADDR_CH4_CTRL, 8'h01);
        chk(rr, `RESP_OKAY);
        wr(5'h14, 8'h01);
        chk(rr, `RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        wr(`ADDR_CH4_CTRL, 8'h05);
        s_axi_wstrb <= 4'hF;
        rd(`ADDR_CH4_CTRL);
        chk(rv, 32'h1);
        for (j = 0; j < 2; j = j + 1)
        begin
            fa = j ? `ADDR_IO_CTRL_LOW : `ADDR_IO_CTRL_HIGH;
            for (k = 0; k < 8; k = k + 1)
            begin
                wr(fa, {k[3:0], 4'h0});
                e = k[1:0] != 0;
                m = (6'h2 | e) << 2 * j | 6'h10 << j;
                sts(m, (e * 2 + k[2]) << 2 * j);
                stim({3'h0, j == 0, j == 1}, 0);
                sts(m, (e * 2 + (k[1:0] == 1 ? 0 : k[1:0] == 2 ? 1 : !k[2])) << 2 * j);
            end
            for (k = 8; k < 16; k = k + 1)
            begin
                wr(fa, {k[3:0], 4'h0});
                sts(6'h2 << 2 * j | 6'h10 << j, 6'h10 << j);
                stim({j == 0, j == 1, 3'h0}, k == 8 || k / 2 == 5);
                stim(5'h0, k == 9 || k / 2 == 5);
                stim(5'h4, k > 11);
            end
            wr(fa, 8'h00);
        end
        wr(`ADDR_IO_CTRL_HIGH, 8'hC0);
        wr(`ADDR_IO_CTRL_LOW, 8'hC0);
        stim(5'h4, 2);
        wr(`ADDR_MODE, 8'h20);
        stim(5'h4, 1);
        wr(`ADDR_CH4_CTRL, 8'h00);
        stim(5'h4, 0);
        wr(`ADDR_IO_CTRL_LOW, 8'h10);
        sts(6'h08, 6'h00);
        conclude;
    end
endmodule // tb
